/* File: design/crs_pkg.sv */
// Constants, types and states shared by the calibration record store
`default_nettype none

package crs_pkg;

  // Store geometry and value widths
  localparam int unsigned REC_COUNT = 50;
  localparam int unsigned IDX_W     = 6;
  localparam int unsigned VAL_W     = 24;
  localparam int unsigned NM_W      = 8;

  // Index limits and step
  localparam logic [IDX_W-1:0] IDX_FIRST = 6'h00;
  localparam logic [IDX_W-1:0] IDX_LAST  = 6'(REC_COUNT - 1);
  localparam logic [IDX_W-1:0] IDX_STEP  = 6'h01;

  // Timing: clock rate and printed times
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned ALLCLR_HOLD_S = 5;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned ALLCLR_HOLD_CYC = ALLCLR_HOLD_S * CLK_HZ;
  localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_HZ / 1000);

  // Warning shown on the display
  typedef enum logic [1:0] {
    WARN_NONE    = 2'h0,
    WARN_REPLACE = 2'h1,
    WARN_CLEAR   = 2'h2,
    WARN_ALLCLR  = 2'h3
  } crs_warn_t;

  // Control states, one-hot
  typedef enum logic [6:0] {
    ST_NORM   = 7'h01,
    ST_SEL    = 7'h02,
    ST_REPL   = 7'h04,
    ST_CALC   = 7'h08,
    ST_READ   = 7'h10,
    ST_CLR1   = 7'h20,
    ST_CLRALL = 7'h40
  } crs_state_t;

  // Front-panel keys, level high while pressed
  typedef struct packed {
    logic mem;
    logic save;
    logic read;
    logic clear;
    logic up;
    logic down;
  } crs_keys_t;

  // One stored record
  typedef struct packed {
    logic             valid;
    logic [VAL_W-1:0] src;
    logic [VAL_W-1:0] meas;
  } crs_rec_t;

  // Display driver word
  typedef struct packed {
    logic             mem_on;
    logic [IDX_W-1:0] idx;
    logic             read_on;
    logic             read_lit;
    crs_warn_t        warn;
    logic             dashes;
    logic [VAL_W-1:0] src;
    logic [VAL_W-1:0] meas;
  } crs_disp_t;

endpackage : crs_pkg

`default_nettype wire

/* File: design/crs_scale.sv */
// Sequential setpoint * n / m scaler for the divided output value
`default_nettype none

module crs_scale
  import crs_pkg::*;
#(
  parameter int unsigned W  = VAL_W,
  parameter int unsigned NW = NM_W
)
(
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic          div_en,
  input  wire logic [W-1:0]  setpoint,
  input  wire logic [NW-1:0] n,
  input  wire logic [NW-1:0] m,
  output var  logic          done,
  output var  logic [W-1:0]  result
);

  localparam int unsigned PW  = W + NW;
  localparam int unsigned CW  = $clog2(PW + 1);
  localparam logic [CW-1:0] STEPS = CW'(PW);

  logic [PW-1:0] quo_ff;
  logic [NW:0]   rem_ff;
  logic [CW-1:0] cnt_ff;
  logic          busy_ff;
  logic [NW-1:0] m_ff;

  // One restoring step: shift in next dividend bit, subtract if it fits
  wire  [NW:0]   rem_sh  = {rem_ff[NW-1:0], quo_ff[PW-1]};
  wire           fits    = rem_sh >= {1'b0, m_ff};
  wire  [NW:0]   rem_sub = rem_sh - {1'b0, m_ff};
  wire  [PW-1:0] product = PW'(setpoint) * PW'(n);
  wire           bypass  = !div_en || (m == '0);
  // Quotient above the value width saturates rather than wrapping
  wire           ovf     = |quo_ff[PW-1:W];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quo_ff  <= '0;
      rem_ff  <= '0;
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      m_ff    <= '0;
      done    <= 1'b0;
      result  <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start && bypass)
      begin
        // Divided output off (or m zero): store the plain setpoint
        result <= setpoint;
        done   <= 1'b1;
      end
      else if (start)
      begin
        quo_ff  <= product;
        rem_ff  <= '0;
        m_ff    <= m;
        cnt_ff  <= STEPS;
        busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
        quo_ff <= {quo_ff[PW-2:0], fits};
        rem_ff <= fits ? rem_sub : rem_sh;
        cnt_ff <= cnt_ff - CW'(1);
        if (cnt_ff == CW'(1))
        begin
          busy_ff <= 1'b0;
          done    <= 1'b1;
          // Last quotient bit still pending in quo_ff; assemble it here
          result  <= (|quo_ff[PW-2:W-1]) ? '1 : {quo_ff[W-2:0], fits};
        end
      end
    end
  end

endmodule : crs_scale

`default_nettype wire

/* File: design/crs_store.sv */
// Key-driven calibration record store: selection, save, read, clear, transfer
`default_nettype none

module crs_store
  import crs_pkg::*;
#(
  parameter int unsigned CLR_HOLD_CYC = ALLCLR_HOLD_CYC,
  parameter int unsigned BLINK_CYC    = BLINK_HALF_CYC
)
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire crs_pkg::crs_keys_t   keys,
  input  wire logic [VAL_W-1:0]     src_setpoint,
  input  wire logic [VAL_W-1:0]     meas_value,
  input  wire logic                 div_en,
  input  wire logic [NM_W-1:0]      div_n,
  input  wire logic [NM_W-1:0]      div_m,
  input  wire logic                 tx_req,
  input  wire logic [IDX_W-1:0]     tx_idx,
  output var  crs_pkg::crs_disp_t   disp_ff,
  output var  logic                 src_off_ff,
  output var  logic                 setp_edit_en_ff,
  output var  logic                 setp_up_ff,
  output var  logic                 setp_dn_ff,
  output var  logic                 tx_valid_ff,
  output var  crs_pkg::crs_rec_t    tx_rec_ff
);

  // Refuse parameter values the logic cannot serve
  if (REC_COUNT > (1 << IDX_W) || REC_COUNT < 2)
  begin : g_bad_count
    $error("crs_store: record count does not fit the index width");
  end
  if (CLR_HOLD_CYC < 2 || BLINK_CYC < 1)
  begin : g_bad_time
    $error("crs_store: hold and blink counts must be at least two and one");
  end

  localparam int unsigned HW = $clog2(CLR_HOLD_CYC + 1);
  localparam int unsigned BW = $clog2(BLINK_CYC + 1);
  localparam logic [HW-1:0] HOLD_DONE  = HW'(CLR_HOLD_CYC);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYC - 1);

  // Index of first slot above the highest valid record, clamped at the last
  function automatic logic [IDX_W-1:0] propose_idx(input logic [REC_COUNT-1:0] v);
    logic [IDX_W-1:0] r;
    r = IDX_FIRST;
    for (int i = 0; i < REC_COUNT; i++)
    begin
      if (v[i])
        r = (IDX_W'(i) == IDX_LAST) ? IDX_LAST : IDX_W'(i) + IDX_STEP;
    end
    return r;
  endfunction : propose_idx

  // Step with saturation at both ends of the store
  function automatic logic [IDX_W-1:0] step_idx(input logic [IDX_W-1:0] i,
                                                input logic up, input logic dn);
    logic [IDX_W-1:0] r;
    r = i;
    if (up && (i != IDX_LAST))
      r = i + IDX_STEP;
    else if (dn && (i != IDX_FIRST))
      r = i - IDX_STEP;
    return r;
  endfunction : step_idx

  crs_state_t       state_ff;
  crs_state_t       nxt_state;
  logic [IDX_W-1:0] idx_ff;
  logic [IDX_W-1:0] nxt_idx;
  crs_keys_t        key_s1_ff;
  crs_keys_t        key_s2_ff;
  crs_keys_t        key_prev_ff;
  logic [HW-1:0]    hold_ff;
  logic [BW-1:0]    blink_cnt_ff;
  logic             blink_ph_ff;
  logic [VAL_W-1:0] meas_cap_ff;
  logic [REC_COUNT-1:0] valid_ff;
  logic [VAL_W-1:0] src_mem  [REC_COUNT];
  logic [VAL_W-1:0] meas_mem [REC_COUNT];
  logic             calc_start;
  logic             calc_done;
  logic [VAL_W-1:0] calc_src;
  logic             wr_en;
  logic             clr_one;
  logic             clr_all;

  // Key pins come from outside the clock domain: two flops first
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_s1_ff   <= '0;
      key_s2_ff   <= '0;
      key_prev_ff <= '0;
    end
    else
    begin
      key_s1_ff   <= keys;
      key_s2_ff   <= key_s1_ff;
      key_prev_ff <= key_s2_ff;
    end
  end

  // Press edges and clear release, all from the second sync stage onward
  wire crs_keys_t press      = key_s2_ff & ~key_prev_ff;
  wire            clr_rel    = key_prev_ff.clear && !key_s2_ff.clear && (hold_ff != '0);
  wire            hold_hit   = (hold_ff == HOLD_DONE);
  wire            cur_valid  = valid_ff[idx_ff];
  wire            tx_in_rng  = (tx_idx <= IDX_LAST);

  // Clear hold timer runs only for a clear press that began in memory select;
  // a key still held after a warning was answered must not re-arm a warning
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hold_ff <= '0;
    else if ((state_ff == ST_SEL) && key_s2_ff.clear && (press.clear || (hold_ff != '0)))
      hold_ff <= hold_hit ? hold_ff : hold_ff + HW'(1);
    else
      hold_ff <= '0;
  end

  // Blink phase for the read indicator; restarts lit on each read entry
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt_ff <= '0;
      blink_ph_ff  <= 1'b1;
    end
    else if (state_ff != ST_READ)
    begin
      blink_cnt_ff <= '0;
      blink_ph_ff  <= 1'b1;
    end
    else if (blink_cnt_ff == BLINK_LAST)
    begin
      blink_cnt_ff <= '0;
      blink_ph_ff  <= !blink_ph_ff;
    end
    else
    begin
      blink_cnt_ff <= blink_cnt_ff + BW'(1);
    end
  end

  // Control state machine: key presses move between the memory states
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_idx    = idx_ff;
    calc_start = 1'b0;
    clr_one    = 1'b0;
    clr_all    = 1'b0;
    unique case (state_ff)
      ST_NORM:
      begin
        if (press.mem)
        begin
          nxt_state = ST_SEL;
          nxt_idx   = propose_idx(valid_ff);
        end
      end
      ST_SEL:
      begin
        if (press.mem)
          nxt_state = ST_NORM;
        else if (press.save)
        begin
          nxt_state  = cur_valid ? ST_REPL : ST_CALC;
          calc_start = !cur_valid;
        end
        else if (press.read)
          nxt_state = ST_READ;
        else if (hold_hit)
          nxt_state = ST_CLRALL;
        else if (clr_rel)
          nxt_state = ST_CLR1;
        else
          nxt_idx = step_idx(idx_ff, press.up, press.down);
      end
      ST_REPL:
      begin
        if (press.mem)
          nxt_state = ST_SEL;
        else if (press.save)
        begin
          nxt_state  = ST_CALC;
          calc_start = 1'b1;
        end
      end
      ST_CALC:
      begin
        if (calc_done)
          nxt_state = ST_NORM;
      end
      ST_READ:
      begin
        if (press.mem || press.read)
          nxt_state = ST_SEL;
        else if (press.clear)
          nxt_state = ST_CLR1;
        else if (press.save)
        begin
          nxt_state  = cur_valid ? ST_REPL : ST_CALC;
          calc_start = !cur_valid;
        end
        else
          nxt_idx = step_idx(idx_ff, press.up, press.down);
      end
      ST_CLR1:
      begin
        if (press.mem)
          nxt_state = ST_SEL;
        else if (press.clear)
        begin
          nxt_state = ST_SEL;
          clr_one   = 1'b1;
        end
      end
      ST_CLRALL:
      begin
        if (press.mem)
          nxt_state = ST_SEL;
        else if (press.clear)
        begin
          nxt_state = ST_SEL;
          clr_all   = 1'b1;
        end
      end
      default:
        nxt_state = ST_NORM;
    endcase
  end

  assign wr_en = (state_ff == ST_CALC) && calc_done;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_NORM;
      idx_ff   <= IDX_FIRST;
    end
    else
    begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
    end
  end

  // Measured value frozen at the save press, while the scaler runs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      meas_cap_ff <= '0;
    else if (calc_start)
      meas_cap_ff <= meas_value;
  end

  // Scaled source value for the record
  crs_scale #(
    .W  (VAL_W),
    .NW (NM_W)
  ) u_scale (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (calc_start),
    .div_en   (div_en),
    .setpoint (src_setpoint),
    .n        (div_n),
    .m        (div_m),
    .done     (calc_done),
    .result   (calc_src)
  );

  // Valid flags: set on save, dropped by single or global clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_ff <= '0;
    end
    else
    begin
      for (int i = 0; i < REC_COUNT; i++)
      begin
        if (clr_all || (clr_one && (idx_ff == IDX_W'(i))))
          valid_ff[i] <= 1'b0;
        else if (wr_en && (idx_ff == IDX_W'(i)))
          valid_ff[i] <= 1'b1;
      end
    end
  end

  // Record payload; no reset needed, the valid flag guards it
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      src_mem[idx_ff]  <= calc_src;
      meas_mem[idx_ff] <= meas_cap_ff;
    end
  end

  // Read-out port for the serial transfer function
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_valid_ff <= 1'b0;
      tx_rec_ff   <= '0;
    end
    else
    begin
      tx_valid_ff <= tx_req;
      if (tx_req)
      begin
        // Empty or out-of-range slots answer zeros, never unwritten payload
        tx_rec_ff <= (tx_in_rng && valid_ff[tx_idx]) ?
                     {1'b1, src_mem[tx_idx], meas_mem[tx_idx]} : '0;
      end
    end
  end

  // Display word and source/setpoint controls, one cycle behind the state
  wire in_read = (state_ff == ST_READ);
  wire in_norm = (state_ff == ST_NORM);
  wire crs_warn_t warn_sel = (state_ff == ST_REPL)   ? WARN_REPLACE :
                             (state_ff == ST_CLR1)   ? WARN_CLEAR :
                             (state_ff == ST_CLRALL) ? WARN_ALLCLR : WARN_NONE;
  wire show_rec = in_read && cur_valid;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      disp_ff         <= '0;
      src_off_ff      <= 1'b0;
      setp_edit_en_ff <= 1'b1;
      setp_up_ff      <= 1'b0;
      setp_dn_ff      <= 1'b0;
    end
    else
    begin
      disp_ff.mem_on   <= !in_norm;
      disp_ff.idx      <= idx_ff + IDX_STEP; // Shown 1-based
      disp_ff.read_on  <= in_read;
      disp_ff.read_lit <= in_read && blink_ph_ff;
      disp_ff.warn     <= warn_sel;
      disp_ff.dashes   <= in_read && !cur_valid;
      disp_ff.src      <= show_rec ? src_mem[idx_ff] : '0;
      disp_ff.meas     <= show_rec ? meas_mem[idx_ff] : '0;
      src_off_ff       <= in_read;
      setp_edit_en_ff  <= in_norm;
      setp_up_ff       <= in_norm && press.up;
      setp_dn_ff       <= in_norm && press.down;
    end
  end

endmodule : crs_store

`default_nettype wire

/* File: bench/crs_chk.sv */
// Port checker for the calibration record store
`default_nettype none

module crs_chk
  import crs_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic               tx_req,
  input wire logic [IDX_W-1:0]   tx_idx,
  input wire crs_pkg::crs_disp_t disp_ff,
  input wire logic               src_off_ff,
  input wire logic               setp_edit_en_ff,
  input wire logic               setp_up_ff,
  input wire logic               setp_dn_ff,
  input wire logic               tx_valid_ff,
  input wire crs_pkg::crs_rec_t  tx_rec_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Request beyond the last record
  sequence s_bad_req;
    tx_req && (tx_idx > IDX_LAST);
  endsequence

  property p_src_off;   disp_ff.read_on == src_off_ff; endproperty
  property p_no_edit;   disp_ff.mem_on |-> !setp_edit_en_ff; endproperty
  property p_no_step;   disp_ff.mem_on |-> !(setp_up_ff || setp_dn_ff); endproperty
  property p_tx_ans;    tx_req |=> tx_valid_ff; endproperty
  property p_tx_only;   tx_valid_ff |-> $past(tx_req); endproperty
  property p_tx_range;  s_bad_req |=> (tx_rec_ff == '0); endproperty
  property p_dash;      disp_ff.dashes |-> disp_ff.read_on && (disp_ff.src == '0); endproperty
  property p_idx_rng;   disp_ff.mem_on |-> (disp_ff.idx >= 6'h01) && (disp_ff.idx <= 6'h32);
  endproperty
  property p_blink;     $rose(disp_ff.read_on) |-> disp_ff.read_lit; endproperty

  a_src_off: assert property (p_src_off) else $error("source not off in read");
  a_no_edit: assert property (p_no_edit) else $error("edit enabled in memory");
  a_no_step: assert property (p_no_step) else $error("setpoint stepped in memory");
  a_tx_ans: assert property (p_tx_ans) else $error("no transfer answer");
  a_tx_only: assert property (p_tx_only) else $error("unrequested transfer");
  a_tx_range: assert property (p_tx_range) else $error("out of range record");
  a_dash: assert property (p_dash) else $error("dashes out of read");
  a_idx_rng: assert property (p_idx_rng) else $error("index out of range");
  a_blink: assert property (p_blink) else $error("read lamp not lit");
endmodule : crs_chk

bind crs_store crs_chk i_crs_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .tx_req(tx_req), .tx_idx(tx_idx),
  .disp_ff(disp_ff), .src_off_ff(src_off_ff), .setp_edit_en_ff(setp_edit_en_ff),
  .setp_up_ff(setp_up_ff), .setp_dn_ff(setp_dn_ff), .tx_valid_ff(tx_valid_ff),
  .tx_rec_ff(tx_rec_ff)
);

`default_nettype wire

/* File: bench/crs_panel.sv */
// Front-panel key model: one key pressed at a time, with release gaps
`default_nettype none

module crs_panel
  import crs_pkg::*;
(
  input  wire logic              clk_sys,
  output var  crs_pkg::crs_keys_t keys
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] kv = 6'h00;

  assign keys = crs_keys_t'(kv);

  // Press bit k for hold cycles, then leave a gap so the next edge is seen
  task automatic press(input int k, input int hold, input int gap);
    @(negedge clk_sys);
    kv[k] = 1'b1;
    repeat (hold) @(negedge clk_sys);
    kv[k] = 1'b0;
    repeat (gap) @(negedge clk_sys);
  endtask : press
endmodule : crs_panel

`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the calibration record store
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import crs_pkg::*;

  localparam int MEM = 5, SAVE = 4, READ = 3, CLR = 2, UP = 1, DN = 0;

  logic             clk_sys = 1'b0;
  logic             rst_n   = 1'b0;
  crs_keys_t        keys;
  logic [VAL_W-1:0] setp    = 24'h000000;
  logic [VAL_W-1:0] meas    = 24'h000000;
  logic             div_en  = 1'b0;
  logic [NM_W-1:0]  div_n   = 8'h00;
  logic [NM_W-1:0]  div_m   = 8'h00;
  logic             tx_req  = 1'b0;
  logic [IDX_W-1:0] tx_idx  = 6'h00;
  crs_disp_t        disp;
  logic             src_off, edit_en, setp_up, setp_dn, tx_valid;
  crs_rec_t         tx_rec;
  int               num_errors = 0;
  int               cmp_count  = 0;
  int               n_up       = 0;
  int               n_dn       = 0;

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

  // Clock
  initial forever #5 clk_sys = ~clk_sys;

  // Setpoint step pulses last one cycle; tally them where they are settled
  always @(negedge clk_sys)
  begin
    n_up <= n_up + int'(setp_up);
    n_dn <= n_dn + int'(setp_dn);
  end

  crs_panel i_crs_panel (.clk_sys(clk_sys), .keys(keys));

  crs_store #(.CLR_HOLD_CYC(40), .BLINK_CYC(4)) i_crs_store (
    .clk_sys(clk_sys), .rst_n(rst_n), .keys(keys), .src_setpoint(setp),
    .meas_value(meas), .div_en(div_en), .div_n(div_n), .div_m(div_m),
    .tx_req(tx_req), .tx_idx(tx_idx), .disp_ff(disp), .src_off_ff(src_off),
    .setp_edit_en_ff(edit_en), .setp_up_ff(setp_up), .setp_dn_ff(setp_dn),
    .tx_valid_ff(tx_valid), .tx_rec_ff(tx_rec)
  );

  task automatic key(input int k, input int gap = 8);
    i_crs_panel.press(k, 2, gap);
  endtask : key

  // Ask the serial side for record i and compare the answer
  task automatic tx(input logic [5:0] i, input crs_rec_t exp);
    @(negedge clk_sys);
    tx_req = 1'b1;
    tx_idx = i;
    @(negedge clk_sys);
    tx_req = 1'b0;
    `CHK(tx_valid, 1'b1)
    `CHK(tx_rec, exp)
  endtask : tx

  task automatic t_save;
    `CHK(edit_en, 1'b1)
    key(UP);
    key(DN);
    `CHK(n_up, 1)
    `CHK(n_dn, 1)
    key(MEM);
    `CHK(disp.idx, 6'h01)
    `CHK(edit_en, 1'b0)
    key(UP);
    key(DN);
    key(SAVE);
    `CHK(disp.mem_on, 1'b0)
    `CHK(n_up + n_dn, 2)
    tx(6'h00, {1'b1, setp, meas});
    key(MEM);
    `CHK(disp.idx, 6'h02)
    key(MEM);
    `CHK(disp.mem_on, 1'b0)
    tx(6'h01, '0);
    $display("t_save done");
  endtask : t_save

  task automatic t_div;
    div_en = 1'b1;
    div_n = 8'h03;
    div_m = 8'h04;
    setp = 24'h000190;
    key(MEM);
    key(SAVE, 60);
    tx(6'h01, {1'b1, 24'h00012C, meas});
    div_en = 1'b0;
    $display("t_div done");
  endtask : t_div

  task automatic t_repl;
    setp = 24'h00ABCD;
    meas = 24'h001234;
    key(MEM);
    `CHK(disp.idx, 6'h03)
    repeat (3) key(DN);
    `CHK(disp.idx, 6'h01)
    key(SAVE);
    `CHK(disp.warn, WARN_REPLACE)
    key(MEM);
    `CHK({disp.mem_on, disp.warn}, {1'b1, WARN_NONE})
    key(SAVE);
    key(SAVE);
    `CHK(disp.mem_on, 1'b0)
    tx(6'h00, {1'b1, 24'h00ABCD, 24'h001234});
    $display("t_repl done");
  endtask : t_repl

  task automatic t_read;
    logic hi, lo;
    hi = 1'b0;
    lo = 1'b0;
    key(MEM);
    key(READ, 0);
    repeat (16)
    begin
      @(negedge clk_sys);
      hi |= disp.read_lit === 1'b1;
      lo |= disp.read_lit === 1'b0;
    end
    `CHK({hi, lo}, 2'b11)
    `CHK({disp.read_on, src_off, disp.dashes}, 3'b111)
    key(DN);
    `CHK({disp.dashes, disp.src}, {1'b0, 24'h00012C})
    key(CLR);
    `CHK(disp.warn, WARN_CLEAR)
    key(MEM);
    `CHK(disp.warn, WARN_NONE)
    tx(6'h01, {1'b1, 24'h00012C, 24'h000055});
    key(READ);
    key(READ);
    `CHK({disp.read_on, src_off, disp.mem_on}, 3'b001)
    key(MEM);
    $display("t_read done");
  endtask : t_read

  task automatic t_clear;
    key(MEM);
    key(DN);
    key(CLR);
    `CHK({disp.warn, disp.idx}, {WARN_CLEAR, 6'h02})
    key(CLR);
    `CHK(disp.warn, WARN_NONE)
    tx(6'h01, '0);
    tx(6'h00, {1'b1, 24'h00ABCD, 24'h001234});
    i_crs_panel.press(CLR, 45, 8);
    `CHK(disp.warn, WARN_ALLCLR)
    key(CLR);
    tx(6'h00, '0);
    key(MEM);
    key(MEM);
    `CHK(disp.idx, 6'h01)
    key(MEM);
    tx(6'h32, '0);
    $display("t_clear done");
  endtask : t_clear

  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    meas = 24'h000055;
    setp = 24'h000077;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_save();
    t_div();
    t_repl();
    t_read();
    t_clear();
    final_report();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    final_report();
  end
endmodule : testbench

`default_nettype wire
